// ### hw/ssmc_regs.vh
// Register map, field positions, reset values and timing for the supervisor mode control.
`ifndef SSMC_REGS_VH
`define SSMC_REGS_VH

// Byte offsets on the APB bus.
`define SSMC_LOW_CTL_OFS     8'h00
`define SSMC_HIGH_CTL_OFS    8'h04
`define SSMC_STATUS_OFS      8'h08
`define SSMC_MASK_OFS        8'h0c
`define SSMC_STATE_OFS       8'h10

// Control register fields, shared by the low-side and high-side registers.
`define SSMC_SUP_EN_BIT      0
`define SSMC_SUP_MD_BIT      1
`define SSMC_SUP_FP_BIT      2
`define SSMC_MON_EN_BIT      3
`define SSMC_MON_FP_BIT      4
`define SSMC_AUTO_BIT        5
`define SSMC_SUP_RST_BIT     6
`define SSMC_MON_RST_BIT     7
`define SSMC_OVP_EN_BIT      8
`define SSMC_CTL_W           9

// Both sides come up enabled in normal mode, kept on in deep sleep.
`define SSMC_LOW_CTL_RST     9'h00b
`define SSMC_HIGH_CTL_RST    9'h00b

// Status and mask layout.
`define SSMC_ST_LOW_SETTLE   0
`define SSMC_ST_HIGH_SETTLE  1
`define SSMC_ST_LSUP_EVT     2
`define SSMC_ST_LMON_EVT     3
`define SSMC_ST_HSUP_EVT     4
`define SSMC_ST_HMON_EVT     5
`define SSMC_ST_OVP_EVT      6
`define SSMC_ST_W            7
`define SSMC_ST_EVT_LO       2
`define SSMC_ST_RST          7'h00

// Unit state encoding.
`define SSMC_UNIT_OFF        2'h0
`define SSMC_UNIT_NORMAL     2'h1
`define SSMC_UNIT_FULL       2'h2

// Power levels: two and above are the deep sleep levels.
`define SSMC_DEEP_LEVEL      3'h2

// Timing in microseconds and clock rate in MHz.
`define SSMC_CLK_MHZ         50
`define SSMC_SLOW_US         150
`define SSMC_FAST_US         2
`define SSMC_CNT_W           16

`endif

// ### hw/ssmc_timer.v
// Down-counting delay timer with a busy flag.
`timescale 1ns/1ps
module ssmc_timer #(
	parameter CW = 16
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          start,
	input  wire [CW-1:0] load,
	output reg           busy_q
);

	reg [CW-1:0] cnt_q;

	// A new start restarts the delay even while it is running.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= {CW{1'b0}};
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q  <= load;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
				cnt_q  <= {CW{1'b0}};
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // ssmc_timer

// ### hw/ssmc_top.v
// Supply supervisor and monitor mode control with APB registers.
//
// Functional notes
// - Both low units normal: 150 us wake hold.
// - Both disabled or both full: 2 us hold.
// - Low supervisor full performance: 2 us settling.
// - Low supervisor normal: 150 us settling.
// - Enabled low unit, not full: slow wake.
// - Enable clear: unit off in every mode.
// - Deep sleep: mode bit, auto control decide.
// - Overvoltage enable: high monitor triggers reset.
// - High auto control: monitor off in sleep.
// - Low events cause reset or interrupt.
`timescale 1ns/1ps
`include "ssmc_regs.vh"
module ssmc_top #(
	parameter SLOW_CYC = `SSMC_SLOW_US * `SSMC_CLK_MHZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [2:0]  lpm_level,
	input  wire        low_sup_trip,
	input  wire        low_mon_trip,
	input  wire        high_sup_trip,
	input  wire        high_mon_trip,
	input  wire        high_over_trip,
	output wire        cpu_hold,
	output reg         por_req,
	output reg         irq,
	output reg  [1:0]  low_sup_state,
	output reg  [1:0]  low_mon_state,
	output reg  [1:0]  high_sup_state,
	output reg  [1:0]  high_mon_state
);

	localparam CW       = `SSMC_CNT_W;
	localparam FAST_CYC = `SSMC_FAST_US * `SSMC_CLK_MHZ;
	localparam [CW-1:0] SLOW_LD = SLOW_CYC[CW-1:0];
	localparam [CW-1:0] FAST_LD = FAST_CYC[CW-1:0];
	localparam NTMR     = 3;
	localparam T_LOW    = 0;
	localparam T_HIGH   = 1;
	localparam T_WAKE   = 2;

	reg  [`SSMC_CTL_W-1:0] low_ctl_q;
	reg  [`SSMC_CTL_W-1:0] high_ctl_q;
	reg  [`SSMC_ST_W-1:0]  evt_q;
	reg  [`SSMC_ST_W-1:0]  mask_q;
	reg                    deep_q;
	wire                   deep_now;
	wire [NTMR-1:0]        tmr_start;
	wire [NTMR*CW-1:0]     tmr_load;
	wire [NTMR-1:0]        tmr_busy;
	wire                   acc;
	wire                   wr_acc;
	wire                   rd_acc;
	wire                   wr_low;
	wire                   wr_high;
	wire                   wr_status;
	wire                   wr_mask;
	wire                   mapped;
	wire                   slow_wake;
	wire                   wake;
	wire [`SSMC_ST_W-1:0]  status;
	wire [`SSMC_ST_W-1:0]  evt_set;
	wire [`SSMC_ST_W-1:0]  evt_clr;
	wire [`SSMC_ST_W-1:0]  evt_d;
	wire                   por_d;
	wire [1:0]             lsup_d;
	wire [1:0]             lmon_d;
	wire [1:0]             hsup_d;
	wire [1:0]             hmon_d;
	wire                   ovp_mode;
	reg  [31:0]            rdata_d;

	// Unit state for one supervisor or monitor. Monitors have no mode bit and
	// pass md=1; kill forces the unit off in deep sleep under auto control.
	function [1:0] unit_state;
		input en;
		input md;
		input fp;
		input auto;
		input deep;
		input kill;
		begin
			if (!en) begin
				unit_state = `SSMC_UNIT_OFF;
			end else if (!deep) begin
				unit_state = fp ? `SSMC_UNIT_FULL : `SSMC_UNIT_NORMAL;
			end else if (!md) begin
				unit_state = `SSMC_UNIT_OFF;
			end else if (!auto) begin
				unit_state = fp ? `SSMC_UNIT_FULL : `SSMC_UNIT_NORMAL;
			end else if (fp && !kill) begin
				unit_state = `SSMC_UNIT_NORMAL;
			end else begin
				unit_state = `SSMC_UNIT_OFF;
			end
		end
	endfunction

	// APB decode. Each access phase lasts two cycles; pready rises in the
	// second one, and writes land on the edge that samples it high.
	assign acc       = psel & penable & pready;
	assign wr_acc    = acc & pwrite;
	assign rd_acc    = psel & penable & ~pready & ~pwrite;
	assign mapped    = (paddr == `SSMC_LOW_CTL_OFS) ||
	                   (paddr == `SSMC_HIGH_CTL_OFS) ||
	                   (paddr == `SSMC_STATUS_OFS) ||
	                   (paddr == `SSMC_MASK_OFS) ||
	                   (paddr == `SSMC_STATE_OFS);
	assign wr_low    = wr_acc & (paddr == `SSMC_LOW_CTL_OFS);
	assign wr_high   = wr_acc & (paddr == `SSMC_HIGH_CTL_OFS);
	assign wr_status = wr_acc & (paddr == `SSMC_STATUS_OFS);
	assign wr_mask   = wr_acc & (paddr == `SSMC_MASK_OFS);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (rd_acc) begin
				prdata <= rdata_d;
			end
		end
	end

	always @* begin
		rdata_d = 32'h0000_0000;
		case (paddr)
		`SSMC_LOW_CTL_OFS: begin
			rdata_d[`SSMC_CTL_W-1:0] = low_ctl_q;
		end
		`SSMC_HIGH_CTL_OFS: begin
			rdata_d[`SSMC_CTL_W-1:0] = high_ctl_q;
		end
		`SSMC_STATUS_OFS: begin
			rdata_d[`SSMC_ST_W-1:0] = status;
		end
		`SSMC_MASK_OFS: begin
			rdata_d[`SSMC_ST_W-1:0] = mask_q;
		end
		`SSMC_STATE_OFS: begin
			rdata_d[7:0] = {high_mon_state, high_sup_state,
			                low_mon_state, low_sup_state};
			rdata_d[8]   = tmr_busy[T_WAKE];
		end
		default: begin
			rdata_d = 32'h0000_0000;
		end
		endcase
	end

	// Control registers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_ctl_q  <= `SSMC_LOW_CTL_RST;
			high_ctl_q <= `SSMC_HIGH_CTL_RST;
			mask_q     <= `SSMC_ST_RST;
		end else begin
			if (wr_low) begin
				low_ctl_q <= pwdata[`SSMC_CTL_W-1:0];
			end
			if (wr_high) begin
				high_ctl_q <= pwdata[`SSMC_CTL_W-1:0];
			end
			if (wr_mask) begin
				mask_q <= pwdata[`SSMC_ST_W-1:0];
			end
		end
	end

	// Power level tracking; leaving deep sleep is a wake.
	assign deep_now = (lpm_level >= `SSMC_DEEP_LEVEL);
	assign wake     = deep_q & ~deep_now;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_q <= 1'b0;
		end else begin
			deep_q <= deep_now;
		end
	end

	// Settling timers restart on every control write; their busy flags are
	// the settle flags. The low delay follows the low supervisor's
	// performance setting, the high delay the high supervisor's.
	assign tmr_start[T_LOW]  = wr_low;
	assign tmr_start[T_HIGH] = wr_high;
	assign tmr_load[T_LOW*CW +: CW] =
		pwdata[`SSMC_SUP_FP_BIT] ? FAST_LD : SLOW_LD;
	assign tmr_load[T_HIGH*CW +: CW] =
		pwdata[`SSMC_SUP_FP_BIT] ? FAST_LD : SLOW_LD;

	// Slow wake whenever an enabled low unit runs in normal performance.
	assign slow_wake =
		(low_ctl_q[`SSMC_SUP_EN_BIT] & ~low_ctl_q[`SSMC_SUP_FP_BIT]) |
		(low_ctl_q[`SSMC_MON_EN_BIT] & ~low_ctl_q[`SSMC_MON_FP_BIT]);
	assign tmr_start[T_WAKE] = wake;
	assign tmr_load[T_WAKE*CW +: CW] = slow_wake ? SLOW_LD : FAST_LD;

	genvar gi;
	generate
		for (gi = 0; gi < NTMR; gi = gi + 1) begin : g_tmr
			ssmc_timer #(
				.CW (CW)
			) u_tmr (
				.pclk    (pclk),
				.presetn (presetn),
				.start   (tmr_start[gi]),
				.load    (tmr_load[gi*CW +: CW]),
				.busy_q  (tmr_busy[gi])
			);
		end
	endgenerate

	assign cpu_hold = tmr_busy[T_WAKE];

	// Unit states for the coming cycle.
	assign lsup_d = unit_state(low_ctl_q[`SSMC_SUP_EN_BIT],
	                           low_ctl_q[`SSMC_SUP_MD_BIT],
	                           low_ctl_q[`SSMC_SUP_FP_BIT],
	                           low_ctl_q[`SSMC_AUTO_BIT], deep_now, 1'b0);
	assign lmon_d = unit_state(low_ctl_q[`SSMC_MON_EN_BIT], 1'b1,
	                           low_ctl_q[`SSMC_MON_FP_BIT],
	                           low_ctl_q[`SSMC_AUTO_BIT], deep_now, 1'b0);
	assign hsup_d = unit_state(high_ctl_q[`SSMC_SUP_EN_BIT],
	                           high_ctl_q[`SSMC_SUP_MD_BIT],
	                           high_ctl_q[`SSMC_SUP_FP_BIT],
	                           high_ctl_q[`SSMC_AUTO_BIT], deep_now, 1'b0);
	assign hmon_d = unit_state(high_ctl_q[`SSMC_MON_EN_BIT], 1'b1,
	                           high_ctl_q[`SSMC_MON_FP_BIT],
	                           high_ctl_q[`SSMC_AUTO_BIT], deep_now,
	                           1'b1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_sup_state  <= `SSMC_UNIT_OFF;
			low_mon_state  <= `SSMC_UNIT_OFF;
			high_sup_state <= `SSMC_UNIT_OFF;
			high_mon_state <= `SSMC_UNIT_OFF;
		end else begin
			low_sup_state  <= lsup_d;
			low_mon_state  <= lmon_d;
			high_sup_state <= hsup_d;
			high_mon_state <= hmon_d;
		end
	end

	// Comparator trips count only from units that are on; all but the overvoltage trip also need their side settled.
	// With overvoltage protection on, the high monitor watches for
	// overvoltage instead of undervoltage.
	assign ovp_mode = high_ctl_q[`SSMC_OVP_EN_BIT];
	assign evt_set[`SSMC_ST_LOW_SETTLE]  = 1'b0;
	assign evt_set[`SSMC_ST_HIGH_SETTLE] = 1'b0;
	assign evt_set[`SSMC_ST_LSUP_EVT] = low_sup_trip & ~tmr_busy[T_LOW] &
		(low_sup_state != `SSMC_UNIT_OFF);
	assign evt_set[`SSMC_ST_LMON_EVT] = low_mon_trip & ~tmr_busy[T_LOW] &
		(low_mon_state != `SSMC_UNIT_OFF);
	assign evt_set[`SSMC_ST_HSUP_EVT] = high_sup_trip & ~tmr_busy[T_HIGH] &
		(high_sup_state != `SSMC_UNIT_OFF);
	assign evt_set[`SSMC_ST_HMON_EVT] = high_mon_trip & ~ovp_mode &
		~tmr_busy[T_HIGH] & (high_mon_state != `SSMC_UNIT_OFF);
	assign evt_set[`SSMC_ST_OVP_EVT] = high_over_trip & ovp_mode &
		(high_mon_state != `SSMC_UNIT_OFF);

	// Sticky event bits; a new event wins over a write-one clear.
	assign evt_clr = wr_status ? pwdata[`SSMC_ST_W-1:0] : `SSMC_ST_RST;
	assign evt_d   = evt_set | (evt_q & ~evt_clr);

	assign status = {evt_q[`SSMC_ST_W-1:`SSMC_ST_EVT_LO],
	                 tmr_busy[T_HIGH], tmr_busy[T_LOW]};

	// Reset request: low events by their select bits, the high supervisor
	// by its select bit, the high monitor by its own or always in
	// overvoltage mode.
	assign por_d =
		(evt_set[`SSMC_ST_LSUP_EVT] & low_ctl_q[`SSMC_SUP_RST_BIT]) |
		(evt_set[`SSMC_ST_LMON_EVT] & low_ctl_q[`SSMC_MON_RST_BIT]) |
		(evt_set[`SSMC_ST_HSUP_EVT] & high_ctl_q[`SSMC_SUP_RST_BIT]) |
		(evt_set[`SSMC_ST_HMON_EVT] & high_ctl_q[`SSMC_MON_RST_BIT]) |
		evt_set[`SSMC_ST_OVP_EVT];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q   <= `SSMC_ST_RST;
			por_req <= 1'b0;
			irq     <= 1'b0;
		end else begin
			evt_q   <= evt_d;
			por_req <= por_d;
			irq     <= |({evt_d[`SSMC_ST_W-1:`SSMC_ST_EVT_LO],
			             tmr_busy[T_HIGH], tmr_busy[T_LOW]} & mask_q);
		end
	end

endmodule // ssmc_top

// ### bench/ssmc_top_sva.sv
// Checker for the supervisor mode control ports.
`timescale 1ns/1ps
`include "ssmc_regs.vh"
module ssmc_top_sva #(
	parameter SLOW_CYC = 7500
) (
	input wire        pclk,
	input wire        presetn,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire [2:0]  lpm_level,
	input wire        high_over_trip,
	input wire        cpu_hold,
	input wire        por_req,
	input wire [1:0]  low_sup_state,
	input wire [1:0]  low_mon_state,
	input wire [1:0]  high_sup_state,
	input wire [1:0]  high_mon_state
);
	localparam int FAST = `SSMC_FAST_US * `SSMC_CLK_MHZ;
	reg  [8:0]  lc_q;
	reg  [8:0]  hc_q;
	reg  [1:0]  ls_q;
	reg  [1:0]  lm_q;
	reg  [1:0]  hs_q;
	reg  [1:0]  hm_q;
	reg  [15:0] n_q;
	wire        dp = lpm_level >= `SSMC_DEEP_LEVEL;
	wire        wr = penable & pready & pwrite;
	wire        slow = lc_q[0] & ~lc_q[2] | lc_q[3] & ~lc_q[4];
	function automatic [1:0] ust(input en, md, fp, au, d);
		if (!en || d && (!md || au && !fp))
			ust = `SSMC_UNIT_OFF;
		else if (fp && !(d && au))
			ust = `SSMC_UNIT_FULL;
		else
			ust = `SSMC_UNIT_NORMAL;
	endfunction
	// Expected unit states trail the settings by one cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lc_q <= `SSMC_LOW_CTL_RST;
			hc_q <= `SSMC_HIGH_CTL_RST;
			{ls_q, lm_q, hs_q, hm_q} <= 8'h00;
			n_q <= 16'h0000;
		end else begin
			if (wr && paddr == `SSMC_LOW_CTL_OFS)
				lc_q <= pwdata[8:0];
			if (wr && paddr == `SSMC_HIGH_CTL_OFS)
				hc_q <= pwdata[8:0];
			ls_q <= ust(lc_q[0], lc_q[1], lc_q[2], lc_q[5], dp);
			lm_q <= ust(lc_q[3], 1'b1, lc_q[4], lc_q[5], dp);
			hs_q <= ust(hc_q[0], hc_q[1], hc_q[2], hc_q[5], dp);
			hm_q <= ust(hc_q[3] & ~(hc_q[5] & dp), 1'b1, hc_q[4], 1'b0, dp);
			n_q <= cpu_hold ? n_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_low_sup_state: assert property (low_sup_state == ls_q)
		else $error("low supervisor state wrong");
	a_low_mon_state: assert property (low_mon_state == lm_q)
		else $error("low monitor state wrong");
	a_high_sup_state: assert property (high_sup_state == hs_q)
		else $error("high supervisor state wrong");
	a_high_mon_auto: assert property (high_mon_state == hm_q)
		else $error("high monitor state wrong");
	a_wake_hold: assert property ($fell(dp) |-> ##[1:4] cpu_hold)
		else $error("no hold after wake");
	a_hold_length: assert property ($fell(cpu_hold) |->
		n_q == (slow ? SLOW_CYC : FAST)) else $error("hold length wrong");
	a_hold_on_wake: assert property ($rose(cpu_hold) |-> !dp)
		else $error("hold raised in sleep");
	a_ovp_reset: assert property (high_over_trip && hc_q[8] &&
		high_mon_state != `SSMC_UNIT_OFF |=> por_req)
		else $error("no reset on overvoltage");
	c_slow: cover property ($fell(cpu_hold) && slow);
	c_fast: cover property ($fell(cpu_hold) && !slow);
	c_ovp: cover property (por_req && hc_q[8]);
endmodule // ssmc_top_sva

bind ssmc_top ssmc_top_sva #(.SLOW_CYC(SLOW_CYC)) u_sva (
	.pclk(pclk), .presetn(presetn), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.lpm_level(lpm_level), .high_over_trip(high_over_trip),
	.cpu_hold(cpu_hold), .por_req(por_req),
	.low_sup_state(low_sup_state), .low_mon_state(low_mon_state),
	.high_sup_state(high_sup_state), .high_mon_state(high_mon_state)
);

// ### bench/ssmc_supply_model.sv
// Supply comparators and power level of the core around the block.
`timescale 1ns/1ps
module ssmc_supply_model #(
	parameter LOW_MV  = 16'h04b0,
	parameter HIGH_MV = 16'h0708,
	parameter OVP_MV  = 16'h0ea6
) (
	input  wire        pclk,
	input  wire [2:0]  level_req,
	input  wire [15:0] core_mv,
	input  wire [15:0] supply_mv,
	output reg  [2:0]  lpm_level = 3'h0,
	output reg         low_sup_trip = 1'b0,
	output reg         low_mon_trip = 1'b0,
	output reg         high_sup_trip = 1'b0,
	output reg         high_mon_trip = 1'b0,
	output reg         high_over_trip = 1'b0
);
	always @(posedge pclk) begin
		lpm_level <= level_req;
		low_sup_trip <= core_mv < LOW_MV;
		low_mon_trip <= core_mv < LOW_MV;
		high_sup_trip <= supply_mv < HIGH_MV;
		high_mon_trip <= supply_mv < HIGH_MV;
		high_over_trip <= supply_mv >= OVP_MV;
	end
endmodule // ssmc_supply_model

// ### bench/test_supply_supervisor_mode_control.sv
// Self-checking bench for the supervisor mode control.
`timescale 1ns/1ps
`include "ssmc_regs.vh"
module test_supply_supervisor_mode_control;
	localparam SLOW = 20;
	localparam FAST = `SSMC_FAST_US * `SSMC_CLK_MHZ;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [2:0]  level_req = 3'h0;
	reg  [15:0] core_mv = 16'h0514;
	reg  [15:0] supply_mv = 16'h0ce4;
	reg  [31:0] rdat;
	reg         serr;
	wire [31:0] prdata;
	wire        pready, pslverr, cpu_hold, por_req, irq;
	wire [2:0]  lpm_level;
	wire [4:0]  trip;
	integer     bad_count, checks_done, por_cnt;
	always #10 pclk = ~pclk;
	always @(posedge pclk) if (por_req === 1'b1) por_cnt <= por_cnt + 1;
	ssmc_supply_model u_sup (.pclk(pclk), .level_req(level_req),
		.core_mv(core_mv), .supply_mv(supply_mv), .lpm_level(lpm_level),
		.low_sup_trip(trip[0]), .low_mon_trip(trip[1]),
		.high_sup_trip(trip[2]), .high_mon_trip(trip[3]),
		.high_over_trip(trip[4]));
	ssmc_top #(.SLOW_CYC(SLOW)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lpm_level(lpm_level),
		.low_sup_trip(trip[0]), .low_mon_trip(trip[1]),
		.high_sup_trip(trip[2]), .high_mon_trip(trip[3]),
		.high_over_trip(trip[4]), .cpu_hold(cpu_hold),
		.por_req(por_req), .irq(irq), .low_sup_state(),
		.low_mon_state(), .high_sup_state(), .high_mon_state());
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("FAIL t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Waits for pready without a cycle limit; the watchdog ends a hang.
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				@(posedge pclk);
			end
			rdat = prdata;
			serr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk(rdat, exp);
		end
	endtask
	task irq_is(input e);
		begin
			@(negedge pclk);
			chk({31'h0, irq}, {31'h0, e});
			@(posedge pclk);
		end
	endtask
	// Software polls both settle flags clear before sleeping.
	task settle;
		integer n;
		begin
			n = 0;
			rdat = 32'h3;
			while (rdat[1:0] !== 2'b00 && n < 300) begin
				apb(1'b0, `SSMC_STATUS_OFS, 32'h0);
				n = n + 1;
			end
			if (rdat[1:0] !== 2'b00)
				bad_count = bad_count + 1;
		end
	endtask
	task wake(input [2:0] lvl, input [8:0] lc, input [8:0] hc,
		input [15:0] exp);
		integer n;
		begin
			apb(1'b1, `SSMC_LOW_CTL_OFS, {23'h0, lc});
			apb(1'b1, `SSMC_HIGH_CTL_OFS, {23'h0, hc});
			settle;
			level_req <= lvl;
			repeat (6) @(posedge pclk);
			level_req <= 3'h0;
			n = 0;
			while (cpu_hold !== 1'b1 && n < 10) begin
				@(posedge pclk);
				n = n + 1;
			end
			n = 0;
			while (cpu_hold === 1'b1 && n < 300) begin
				@(posedge pclk);
				n = n + 1;
			end
			chk(n, {16'h0, exp});
		end
	endtask
	task trip_on(input [15:0] cmv, input [15:0] smv);
		begin
			core_mv <= cmv;
			supply_mv <= smv;
			repeat (3) @(posedge pclk);
			supply_mv <= 16'h0ce4;
			core_mv <= 16'h0514;
			repeat (4) @(posedge pclk);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks_done, bad_count);
			if (bad_count == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		#400000;
		bad_count = bad_count + 1;
		test_done;
	end
	initial begin
		bad_count = 0;
		checks_done = 0;
		por_cnt = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SSMC_LOW_CTL_OFS, 32'h00b);
		rd(`SSMC_HIGH_CTL_OFS, 32'h00b);
		rd(`SSMC_MASK_OFS, 32'h0);
		apb(1'b1, `SSMC_STATE_OFS, 32'hffff);
		rd(`SSMC_STATE_OFS, 32'h055);
		apb(1'b1, 8'h14, 32'hffff);
		rd(8'h14, 32'h0);
		chk({31'h0, serr}, 32'h1);
		$display("register test done");
		apb(1'b1, `SSMC_LOW_CTL_OFS, 32'h00b);
		rd(`SSMC_STATUS_OFS, 32'h1);
		apb(1'b1, `SSMC_MASK_OFS, 32'h01);
		irq_is(1'b1);
		repeat (30) @(posedge pclk);
		rd(`SSMC_STATUS_OFS, 32'h0);
		irq_is(1'b0);
		apb(1'b1, `SSMC_LOW_CTL_OFS, 32'h00f);
		repeat (30) @(posedge pclk);
		rd(`SSMC_STATUS_OFS, 32'h1);
		repeat (80) @(posedge pclk);
		rd(`SSMC_STATUS_OFS, 32'h0);
		$display("settle test done");
		wake(3'h3, 9'h00b, 9'h00b, SLOW);
		wake(3'h4, 9'h000, 9'h02b, FAST);
		wake(3'h2, 9'h01f, 9'h03f, FAST);
		wake(3'h3, 9'h027, 9'h005, FAST);
		wake(3'h4, 9'h029, 9'h01b, SLOW);
		$display("wake test done");
		apb(1'b1, `SSMC_MASK_OFS, 32'h7c);
		apb(1'b1, `SSMC_LOW_CTL_OFS, 32'h00b);
		settle;
		trip_on(16'h03e8, 16'h0ce4);
		rd(`SSMC_STATUS_OFS, 32'h0c);
		irq_is(1'b1);
		chk(por_cnt, 32'h0);
		apb(1'b1, `SSMC_MASK_OFS, 32'h0);
		irq_is(1'b0);
		apb(1'b1, `SSMC_STATUS_OFS, 32'h0c);
		rd(`SSMC_STATUS_OFS, 32'h0);
		apb(1'b1, `SSMC_MASK_OFS, 32'h7c);
		apb(1'b1, `SSMC_LOW_CTL_OFS, 32'h04b);
		settle;
		trip_on(16'h03e8, 16'h0ce4);
		chk(por_cnt, 32'h3);
		apb(1'b1, `SSMC_STATUS_OFS, 32'h0c);
		apb(1'b1, `SSMC_HIGH_CTL_OFS, 32'h10b);
		settle;
		trip_on(16'h0514, 16'h0ed8);
		chk(por_cnt, 32'h6);
		rd(`SSMC_STATUS_OFS, 32'h40);
		irq_is(1'b1);
		// High-side undervoltage with both reset selects set.
		apb(1'b1, `SSMC_STATUS_OFS, 32'h40);
		apb(1'b1, `SSMC_HIGH_CTL_OFS, 32'h0cb);
		settle;
		trip_on(16'h0514, 16'h0600);
		chk(por_cnt, 32'h9);
		rd(`SSMC_STATUS_OFS, 32'h30);
		$display("event test done");
		test_done;
	end
endmodule // test_supply_supervisor_mode_control
